// ===== logic/epdma.sv
// eight-channel peripheral dma: register file, arbiter and transfer engine
// assumes one 50 mhz clock, request lines and both buses on that clock,
// ram and peripheral read data valid in the same cycle as the read strobe
//
// Functional notes
// - eight independent channels, own registers each
// - transfers use dedicated bus, not software bus
// - control bit 15 enables the channel
// - control bit 14 selects byte, else word
// - control bit 13 set moves ram to peripheral
// - control bit 12 chooses half-block interrupt
// - bit 11 adds null peripheral write after peripheral-to-ram transfers only
// - bits 5-4 select ram addressing style
// - peripheral indirect adds peripheral-supplied address bits
// - bits 1-0 select continuous, one-shot, ping-pong
// - one-shot stops after one block
// - continuous reloads start address every block
// - ping-pong alternates first and second buffers
// - two 16-bit start addresses, reset zero
// - 16-bit peripheral address per channel
// - 10-bit transfer count sets block length
// - 7-bit field picks one of 128 requests
// - request codes numbered as peripheral table
// - request-select bit 15 forces one transfer
// - force ignores software clear, hardware clears
// - per-channel interrupt at block end or half
// - transfers per block equal count plus one
// - status shows which buffer ping-pong uses
`timescale 1ns/1ps
`include "epdma_regs.svh"

module epdma (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic [8:0]   avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_writedata,
   input  wire logic [3:0]   avs_byteenable,
   output logic      [31:0]  avs_readdata,
   output logic              avs_waitrequest,
   input  wire logic [127:0] per_req,
   input  wire logic [10:0]  per_ind_offset,
   output logic      [15:0]  ram_addr,
   output logic              ram_rd,
   output logic              ram_wr,
   output logic      [15:0]  ram_wdata,
   output logic      [1:0]   ram_be,
   input  wire logic [15:0]  ram_rdata,
   output logic      [15:0]  per_addr,
   output logic              per_rd,
   output logic              per_wr,
   output logic      [15:0]  per_wdata,
   output logic      [1:0]   per_be,
   input  wire logic [15:0]  per_rdata,
   output logic      [7:0]   chan_irq
);

   epdma_pkg::epdma_state_t st_ff;
   epdma_pkg::epdma_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // lowest set bit wins
   function automatic logic [2:0] epdma_first(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         if (m[k]) begin
            r = 3'(k);
         end
      end
      return r;
   endfunction

   // byte lane merge of a 16-bit register write
   function automatic logic [15:0] epdma_merge(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] be, input logic [15:0] msk);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = (wd[7:0] & msk[7:0]) | (old[7:0] & ~msk[7:0]);
      end
      if (be[1]) begin
         r[15:8] = (wd[15:8] & msk[15:8]) | (old[15:8] & ~msk[15:8]);
      end
      return r;
   endfunction

   // ram start of the buffer in use
   function automatic logic [15:0] epdma_origin(input epdma_pkg::epdma_state_t s, input logic [2:0] c,
                                                input logic alt);
      return alt ? s.second_org[c] : s.first_org[c];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // avalon decode
   logic        sel_status;
   logic        sel_chan;
   logic [2:0]  sel_ch;
   logic [2:0]  sel_ofs;
   logic [31:0] rd_word;

   assign sel_status = (avs_address[8:2] == 7'(`EPDMA_STATUS_ADDR >> 2));
   assign sel_ch     = avs_address[7:5];
   assign sel_ofs    = avs_address[4:2];
   assign sel_chan   = ~avs_address[8] && (sel_ofs <= `EPDMA_OFS_TALLY);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (sel_status) begin
         rd_word = {20'h00000, st_ff.last_ch, st_ff.alt_buf};
      end else if (sel_chan) begin
         case (sel_ofs)
            `EPDMA_OFS_CONTROL:      rd_word = {16'h0000, st_ff.ctl[sel_ch]};
            `EPDMA_OFS_REQ_SELECT:   rd_word = {16'h0000, st_ff.req[sel_ch]};
            `EPDMA_OFS_FIRST_ORIGIN: rd_word = {16'h0000, st_ff.first_org[sel_ch]};
            `EPDMA_OFS_SECOND_ORIG:  rd_word = {16'h0000, st_ff.second_org[sel_ch]};
            `EPDMA_OFS_PERIPH_LOC:   rd_word = {16'h0000, st_ff.per_loc[sel_ch]};
            `EPDMA_OFS_TALLY:        rd_word = {22'h000000, st_ff.tally[sel_ch]};
            default:                 rd_word = 32'h0000_0000;
         endcase
      end
   end

   // reads take one wait cycle, writes none
   assign avs_waitrequest = avs_read && !st_ff.rd_ack;
   assign avs_readdata    = st_ff.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   logic [7:0]  ready_mask;
   logic [2:0]  c;
   logic        to_per;
   logic        byte_mode;
   logic [15:0] src_data;
   logic [15:0] mv_data;
   logic        fin;
   logic        force_set;
   logic [15:0] new_ctl;
   logic [15:0] base;

   always_comb begin
      nxt_st     = st_ff;
      ready_mask = 8'h00;
      c          = st_ff.ch;
      to_per     = st_ff.ctl[st_ff.ch][`EPDMA_CTL_RAM_TO_PER];
      byte_mode  = st_ff.ctl[st_ff.ch][`EPDMA_CTL_BYTE_SIZE];
      src_data   = to_per ? ram_rdata : per_rdata;
      mv_data    = src_data;
      fin        = 1'b0;
      force_set  = 1'b0;
      new_ctl    = 16'h0000;
      base       = 16'h0000;

      nxt_st.ram_rd = 1'b0;
      nxt_st.ram_wr = 1'b0;
      nxt_st.per_rd = 1'b0;
      nxt_st.per_wr = 1'b0;
      nxt_st.irq    = 8'h00;
      nxt_st.rd_ack = avs_read && !st_ff.rd_ack;
      if (avs_read && !st_ff.rd_ack) begin
         nxt_st.rdata = rd_word;
      end

      // software side, one set of registers per channel
      if (avs_write && sel_chan) begin
         case (sel_ofs)
            `EPDMA_OFS_CONTROL: begin
               new_ctl = epdma_merge(st_ff.ctl[sel_ch], avs_writedata, avs_byteenable, `EPDMA_CTL_WR_MASK);
               nxt_st.ctl[sel_ch] = new_ctl;
               if (new_ctl[`EPDMA_CTL_CHANNEL_ON] && !st_ff.ctl[sel_ch][`EPDMA_CTL_CHANNEL_ON]) begin
                  nxt_st.cur_addr[sel_ch] = st_ff.first_org[sel_ch];
                  nxt_st.done_idx[sel_ch] = 10'h000;
                  nxt_st.alt_buf[sel_ch]  = 1'b0;
                  nxt_st.pend[sel_ch]     = 1'b0;
               end
            end
            `EPDMA_OFS_REQ_SELECT: begin
               nxt_st.req[sel_ch][`EPDMA_REQ_SRC_HI:`EPDMA_REQ_SRC_LO] = avs_byteenable[0] ?
                  avs_writedata[`EPDMA_REQ_SRC_HI:`EPDMA_REQ_SRC_LO] :
                  st_ff.req[sel_ch][`EPDMA_REQ_SRC_HI:`EPDMA_REQ_SRC_LO];
               force_set = avs_byteenable[1] && avs_writedata[`EPDMA_REQ_FORCE];
            end
            `EPDMA_OFS_FIRST_ORIGIN: begin
               nxt_st.first_org[sel_ch] = epdma_merge(st_ff.first_org[sel_ch], avs_writedata,
                                                      avs_byteenable, 16'hFFFF);
            end
            `EPDMA_OFS_SECOND_ORIG: begin
               nxt_st.second_org[sel_ch] = epdma_merge(st_ff.second_org[sel_ch], avs_writedata,
                                                       avs_byteenable, 16'hFFFF);
            end
            `EPDMA_OFS_PERIPH_LOC: begin
               nxt_st.per_loc[sel_ch] = epdma_merge(st_ff.per_loc[sel_ch], avs_writedata,
                                                    avs_byteenable, 16'hFFFF);
            end
            `EPDMA_OFS_TALLY: begin
               nxt_st.tally[sel_ch] = 10'(epdma_merge({6'h00, st_ff.tally[sel_ch]}, avs_writedata,
                                                      avs_byteenable, 16'h03FF));
            end
            default: begin
            end
         endcase
      end

      // transfer engine on its own ram/peripheral buses
      for (int i = 0; i < 8; i++) begin
         ready_mask[i] = st_ff.ctl[i][`EPDMA_CTL_CHANNEL_ON] &&
                         (st_ff.pend[i] || st_ff.req[i][`EPDMA_REQ_FORCE]);
      end

      case (st_ff.fsm)
         epdma_pkg::EPDMA_IDLE: begin
            if (ready_mask != 8'h00) begin
               c = epdma_first(ready_mask);
               nxt_st.ch = c;
               nxt_st.pend[c] = 1'b0;
               base = epdma_origin(st_ff, c, st_ff.alt_buf[c]);
               if (st_ff.ctl[c][`EPDMA_CTL_ADDR_HI:`EPDMA_CTL_ADDR_LO] == `EPDMA_ADDR_PERIPH_IND) begin
                  nxt_st.xaddr = base + {5'h00, per_ind_offset};
               end else begin
                  nxt_st.xaddr = st_ff.cur_addr[c];
               end
               nxt_st.paddr = st_ff.per_loc[c];
               if (st_ff.ctl[c][`EPDMA_CTL_RAM_TO_PER]) begin
                  nxt_st.ram_rd   = 1'b1;
                  nxt_st.ram_addr = nxt_st.xaddr;
                  nxt_st.ram_be   = st_ff.ctl[c][`EPDMA_CTL_BYTE_SIZE] ?
                                    (nxt_st.xaddr[0] ? 2'h2 : 2'h1) : 2'h3;
               end else begin
                  nxt_st.per_rd   = 1'b1;
                  nxt_st.per_addr = st_ff.per_loc[c];
                  nxt_st.per_be   = st_ff.ctl[c][`EPDMA_CTL_BYTE_SIZE] ?
                                    (st_ff.per_loc[c][0] ? 2'h2 : 2'h1) : 2'h3;
               end
               nxt_st.fsm = epdma_pkg::EPDMA_READ;
            end
         end
         epdma_pkg::EPDMA_READ: begin
            if (byte_mode) begin
               if (to_per ? st_ff.xaddr[0] : st_ff.paddr[0]) begin
                  mv_data = {src_data[15:8], src_data[15:8]};
               end else begin
                  mv_data = {src_data[7:0], src_data[7:0]};
               end
            end
            if (to_per) begin
               nxt_st.per_wr    = 1'b1;
               nxt_st.per_addr  = st_ff.paddr;
               nxt_st.per_wdata = mv_data;
               nxt_st.per_be    = byte_mode ? (st_ff.paddr[0] ? 2'h2 : 2'h1) : 2'h3;
            end else begin
               nxt_st.ram_wr    = 1'b1;
               nxt_st.ram_addr  = st_ff.xaddr;
               nxt_st.ram_wdata = mv_data;
               nxt_st.ram_be    = byte_mode ? (st_ff.xaddr[0] ? 2'h2 : 2'h1) : 2'h3;
            end
            nxt_st.fsm = epdma_pkg::EPDMA_WRITE;
         end
         epdma_pkg::EPDMA_WRITE: begin
            if (st_ff.ctl[c][`EPDMA_CTL_DUMMY_WR] && !to_per) begin
               nxt_st.per_wr    = 1'b1;
               nxt_st.per_addr  = st_ff.paddr;
               nxt_st.per_wdata = 16'h0000;
               nxt_st.per_be    = byte_mode ? (st_ff.paddr[0] ? 2'h2 : 2'h1) : 2'h3;
               nxt_st.fsm       = epdma_pkg::EPDMA_DUMMY;
            end else begin
               fin        = 1'b1;
               nxt_st.fsm = epdma_pkg::EPDMA_IDLE;
            end
         end
         epdma_pkg::EPDMA_DUMMY: begin
            fin        = 1'b1;
            nxt_st.fsm = epdma_pkg::EPDMA_IDLE;
         end
         default: begin
            nxt_st.fsm = epdma_pkg::EPDMA_IDLE;
         end
      endcase

      // bookkeeping after the last write of a transfer
      if (fin) begin
         nxt_st.last_ch = {1'b0, c};
         nxt_st.req[c][`EPDMA_REQ_FORCE] = 1'b0;
         if (st_ff.ctl[c][`EPDMA_CTL_ADDR_HI:`EPDMA_CTL_ADDR_LO] == `EPDMA_ADDR_POST_INC) begin
            nxt_st.cur_addr[c] = st_ff.cur_addr[c] + (byte_mode ? 16'h0001 : 16'h0002);
         end
         if (st_ff.ctl[c][`EPDMA_CTL_HALF_IRQ] && st_ff.done_idx[c] == (st_ff.tally[c] >> 1)) begin
            nxt_st.irq[c] = 1'b1;
         end
         if (st_ff.done_idx[c] == st_ff.tally[c]) begin
            nxt_st.done_idx[c] = 10'h000;
            if (!st_ff.ctl[c][`EPDMA_CTL_HALF_IRQ]) begin
               nxt_st.irq[c] = 1'b1;
            end
            case (st_ff.ctl[c][`EPDMA_CTL_MODE_HI:`EPDMA_CTL_MODE_LO])
               `EPDMA_MODE_CONT: begin
                  nxt_st.cur_addr[c] = st_ff.first_org[c];
               end
               `EPDMA_MODE_ONESHOT: begin
                  nxt_st.ctl[c][`EPDMA_CTL_CHANNEL_ON] = 1'b0;
               end
               `EPDMA_MODE_CONT_PP: begin
                  nxt_st.alt_buf[c]  = ~st_ff.alt_buf[c];
                  nxt_st.cur_addr[c] = epdma_origin(st_ff, c, ~st_ff.alt_buf[c]);
               end
               default: begin
                  nxt_st.alt_buf[c]  = ~st_ff.alt_buf[c];
                  nxt_st.cur_addr[c] = epdma_origin(st_ff, c, ~st_ff.alt_buf[c]);
                  if (st_ff.alt_buf[c]) begin
                     nxt_st.ctl[c][`EPDMA_CTL_CHANNEL_ON] = 1'b0;
                  end
               end
            endcase
         end else begin
            nxt_st.done_idx[c] = st_ff.done_idx[c] + 10'h001;
         end
      end

      // events win over clears in the same cycle
      for (int i = 0; i < 8; i++) begin
         if (st_ff.ctl[i][`EPDMA_CTL_CHANNEL_ON] &&
             per_req[st_ff.req[i][`EPDMA_REQ_SRC_HI:`EPDMA_REQ_SRC_LO]]) begin
            nxt_st.pend[i] = 1'b1;
         end
      end
      if (force_set) begin
         nxt_st.req[sel_ch][`EPDMA_REQ_FORCE] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ff         <= '0;
         st_ff.fsm     <= epdma_pkg::EPDMA_IDLE;
         st_ff.last_ch <= `EPDMA_RST_LAST_CH;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign ram_addr  = st_ff.ram_addr;
   assign ram_rd    = st_ff.ram_rd;
   assign ram_wr    = st_ff.ram_wr;
   assign ram_wdata = st_ff.ram_wdata;
   assign ram_be    = st_ff.ram_be;
   assign per_addr  = st_ff.per_addr;
   assign per_rd    = st_ff.per_rd;
   assign per_wr    = st_ff.per_wr;
   assign per_wdata = st_ff.per_wdata;
   assign per_be    = st_ff.per_be;
   assign chan_irq  = st_ff.irq;

endmodule

// ===== logic/epdma_pkg.sv
// types of the eight-channel peripheral dma
// assumes epdma_regs.svh is compiled alongside
package epdma_pkg;

   typedef enum logic [1:0] {
      EPDMA_IDLE = 2'b00,
      EPDMA_READ = 2'b01,
      EPDMA_WRITE = 2'b11,
      EPDMA_DUMMY = 2'b10
   } epdma_fsm_t;

   typedef struct packed {
      logic [7:0][15:0] ctl;
      logic [7:0][15:0] req;
      logic [7:0][15:0] first_org;
      logic [7:0][15:0] second_org;
      logic [7:0][15:0] per_loc;
      logic [7:0][9:0]  tally;
      logic [7:0][15:0] cur_addr;
      logic [7:0][9:0]  done_idx;
      logic [7:0]       alt_buf;
      logic [7:0]       pend;
      epdma_fsm_t       fsm;
      logic [2:0]       ch;
      logic [15:0]      xaddr;
      logic [15:0]      paddr;
      logic [15:0]      ram_addr;
      logic             ram_rd;
      logic             ram_wr;
      logic [15:0]      ram_wdata;
      logic [1:0]       ram_be;
      logic [15:0]      per_addr;
      logic             per_rd;
      logic             per_wr;
      logic [15:0]      per_wdata;
      logic [1:0]       per_be;
      logic [7:0]       irq;
      logic [3:0]       last_ch;
      logic             rd_ack;
      logic [31:0]      rdata;
   } epdma_state_t;

endpackage

// ===== logic/epdma_regs.svh
// register offsets, field positions, reset values of the eight-channel dma
// assumes byte addressing on a 32-bit avalon-mm slave, one word per register
`ifndef EPDMA_REGS_SVH
`define EPDMA_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// channel window: channel n at n * stride, register at offset inside
`define EPDMA_CH_STRIDE        9'h020
`define EPDMA_OFS_CONTROL      3'h0
`define EPDMA_OFS_REQ_SELECT   3'h1
`define EPDMA_OFS_FIRST_ORIGIN 3'h2
`define EPDMA_OFS_SECOND_ORIG  3'h3
`define EPDMA_OFS_PERIPH_LOC   3'h4
`define EPDMA_OFS_TALLY        3'h5
`define EPDMA_STATUS_ADDR      9'h100

////////////////////////////////////////////////////////////////////////////////
// channel_control fields
`define EPDMA_CTL_CHANNEL_ON   15
`define EPDMA_CTL_BYTE_SIZE    14
`define EPDMA_CTL_RAM_TO_PER   13
`define EPDMA_CTL_HALF_IRQ     12
`define EPDMA_CTL_DUMMY_WR     11
`define EPDMA_CTL_ADDR_HI      5
`define EPDMA_CTL_ADDR_LO      4
`define EPDMA_CTL_MODE_HI      1
`define EPDMA_CTL_MODE_LO      0
`define EPDMA_CTL_WR_MASK      16'hF833

////////////////////////////////////////////////////////////////////////////////
// channel_request_select fields
`define EPDMA_REQ_FORCE        15
`define EPDMA_REQ_SRC_HI       6
`define EPDMA_REQ_SRC_LO       0

////////////////////////////////////////////////////////////////////////////////
// encodings and reset values
`define EPDMA_ADDR_POST_INC    2'h0
`define EPDMA_ADDR_FIXED       2'h1
`define EPDMA_ADDR_PERIPH_IND  2'h2
`define EPDMA_MODE_CONT        2'h0
`define EPDMA_MODE_ONESHOT     2'h1
`define EPDMA_MODE_CONT_PP     2'h2
`define EPDMA_MODE_ONESHOT_PP  2'h3
`define EPDMA_TALLY_W          10
`define EPDMA_RST_REG          16'h0000
`define EPDMA_RST_LAST_CH      4'hF

`endif

// ===== verif/epdma_monitor.sv
// concurrent checks on the ports of the eight-channel dma
// assumes single clock mclk, synchronous active-high sys_rst
`timescale 1ns/1ps
module epdma_monitor (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic        ram_rd,
   input wire logic        ram_wr,
   input wire logic [15:0] ram_wdata,
   input wire logic [1:0]  ram_be,
   input wire logic        per_rd,
   input wire logic        per_wr,
   input wire logic [15:0] per_wdata,
   input wire logic [7:0]  chan_irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_rst_quiet;
      $fell(sys_rst) |-> !ram_rd && !ram_wr && !per_rd && !per_wr && chan_irq == 8'h00 && avs_readdata == 32'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   property p_read_wait;
      $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read answer late");
   property p_write_free;
      avs_write |-> !avs_waitrequest;
   endproperty
   a_write_free: assert property (p_write_free) else $error("write stalled");
   property p_per_to_ram;
      per_rd |=> ram_wr && !ram_rd;
   endproperty
   a_per_to_ram: assert property (p_per_to_ram) else $error("peripheral read not followed by ram write");
   property p_ram_to_per;
      ram_rd |=> per_wr && !ram_wr;
   endproperty
   a_ram_to_per: assert property (p_ram_to_per) else $error("ram read not followed by peripheral write");
   property p_byte_lane;
      ram_wr && ram_be != 2'h3 |-> (ram_be == 2'h1 || ram_be == 2'h2) && ram_wdata[15:8] == ram_wdata[7:0];
   endproperty
   a_byte_lane: assert property (p_byte_lane) else $error("bad byte lane");
   property p_null_write;
      per_wr && $past(ram_wr) |-> per_wdata == 16'h0000;
   endproperty
   a_null_write: assert property (p_null_write) else $error("dummy write data not zero");
   property p_one_transfer;
      ram_wr |=> !ram_wr[*2];
   endproperty
   a_one_transfer: assert property (p_one_transfer) else $error("transfers overlap");
   property p_irq_cause;
      chan_irq != 8'h00 |-> $onehot(chan_irq) && ($past(ram_wr) || $past(per_wr) || $past(ram_wr, 2) || $past(per_wr, 2));
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without transfer");
endmodule

bind epdma epdma_monitor epdma_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .ram_rd(ram_rd),
   .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_be(ram_be), .per_rd(per_rd), .per_wr(per_wr),
   .per_wdata(per_wdata), .chan_irq(chan_irq));

// ===== verif/epdma_partner.sv
// model of dma ram and a peripheral register
// assumes byte addresses, read data answered within the strobe cycle
`timescale 1ns/1ps
module epdma_partner (
   input  wire logic        mclk,
   input  wire logic [15:0] ram_addr,
   input  wire logic        ram_rd,
   input  wire logic        ram_wr,
   input  wire logic [15:0] ram_wdata,
   input  wire logic [1:0]  ram_be,
   output logic      [15:0] ram_rdata,
   input  wire logic        per_rd,
   input  wire logic        per_wr,
   input  wire logic [15:0] per_wdata,
   output logic      [15:0] per_rdata
);
   logic [15:0] ram_mem [0:255];
   logic [7:0]  n_prd;
   int          n_pwr;
   logic [15:0] last_pwdata;
   initial begin
      n_prd = 8'h00;
      n_pwr = 0;
      last_pwdata = 16'h0000;
      for (int i = 0; i < 256; i++) ram_mem[i] = 16'h0000;
   end
   // read data only while the strobe stands, inverted otherwise
   assign ram_rdata = ram_rd ? ram_mem[ram_addr[8:1]] : ~ram_mem[ram_addr[8:1]];
   assign per_rdata = per_rd ? {8'hA5, n_prd} : ~{8'hA5, n_prd};
   always @(posedge mclk) begin
      if (per_rd) n_prd <= n_prd + 8'h01;
      if (ram_wr && ram_be[0]) ram_mem[ram_addr[8:1]][7:0] <= ram_wdata[7:0];
      if (ram_wr && ram_be[1]) ram_mem[ram_addr[8:1]][15:8] <= ram_wdata[15:8];
      if (per_wr) n_pwr <= n_pwr + 1;
      if (per_wr) last_pwdata <= per_wdata;
   end
endmodule

// ===== verif/tb_epdma.sv
// self-checking bench of the eight-channel dma
// assumes epdma, its checker and the partner model compiled first
`timescale 1ns/1ps
module tb_epdma;
   logic          mclk;
   logic          sys_rst;
   logic [8:0]    avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [3:0]    avs_byteenable;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [127:0]  per_req;
   logic [10:0]   per_ind_offset;
   logic [15:0]   ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
   logic          ram_rd, ram_wr, per_rd, per_wr, hit;
   logic [1:0]    ram_be, per_be;
   logic [7:0]    chan_irq, p0;
   logic [31:0]   rv;
   int            errors, n_compared, n0;

   epdma epdma_inst (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .per_req(per_req),
      .per_ind_offset(per_ind_offset), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
      .ram_wdata(ram_wdata), .ram_be(ram_be), .ram_rdata(ram_rdata), .per_addr(per_addr), .per_rd(per_rd),
      .per_wr(per_wr), .per_wdata(per_wdata), .per_be(per_be), .per_rdata(per_rdata), .chan_irq(chan_irq));
   epdma_partner epdma_partner_inst (.mclk(mclk), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
      .ram_wdata(ram_wdata), .ram_be(ram_be), .ram_rdata(ram_rdata), .per_rd(per_rd), .per_wr(per_wr),
      .per_wdata(per_wdata), .per_rdata(per_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d);
      logic wt;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(negedge mclk);
         wt = avs_waitrequest;
         rv = avs_readdata;
         @(posedge mclk);
      end while (wt !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
      bus(1'b0, a, 16'h0000);
      chk(rv, exp);
   endtask
   function automatic logic [8:0] ra(input int ch, input int ofs);
      return 9'(ch * 32 + ofs * 4);
   endfunction
   // one request pulse, then watch the channel interrupt
   task automatic pulse(input int code, input int ch);
      per_req[code] <= 1'b1;
      @(posedge mclk);
      per_req[code] <= 1'b0;
      hit = 1'b0;
      repeat (12) begin
         @(negedge mclk);
         if (chan_irq[ch] === 1'b1) hit = 1'b1;
      end
      @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rdchk(ra(0, 0), 32'h0);
      rdchk(ra(3, 3), 32'h0);
      rdchk(9'h100, 32'h00000F00);
      bus(1'b1, ra(3, 0), 16'h7FFF);
      rdchk(ra(3, 0), 32'h00007833);
      bus(1'b1, ra(3, 1), 16'h007F);
      rdchk(ra(3, 1), 32'h0000007F);
      bus(1'b1, ra(3, 6), 16'hFFFF);
      rdchk(ra(3, 6), 32'h0);
      $display("test regs done");
   endtask
   task automatic t_cont();
      bus(1'b1, ra(2, 2), 16'h0010);
      bus(1'b1, ra(2, 5), 16'h0003);
      bus(1'b1, ra(2, 1), 16'h000B);
      bus(1'b1, ra(2, 0), 16'h8000);
      p0 = epdma_partner_inst.n_prd;
      for (int i = 0; i < 4; i++) begin
         pulse(11, 2);
         chk(hit, i == 3);
      end
      for (int i = 0; i < 4; i++) begin
         chk(epdma_partner_inst.ram_mem[8 + i], {8'hA5, p0 + 8'(i)});
      end
      pulse(11, 2);
      chk(epdma_partner_inst.ram_mem[8], {8'hA5, p0 + 8'h04});
      bus(1'b1, ra(2, 0), 16'h0000);
      $display("test continuous done");
   endtask
   task automatic t_force();
      epdma_partner_inst.ram_mem[8'h10] = 16'h1234;
      bus(1'b1, ra(5, 2), 16'h0021);
      bus(1'b1, ra(5, 5), 16'h0001);
      bus(1'b1, ra(5, 4), 16'h0043);
      bus(1'b1, ra(5, 0), 16'hE011);
      n0 = epdma_partner_inst.n_pwr;
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, ra(5, 1), 16'h8000);
         repeat (8) @(posedge mclk);
      end
      chk(epdma_partner_inst.last_pwdata, 32'h1212);
      chk(per_addr, 32'h00000043);
      chk(per_be, 32'h00000002);
      chk(epdma_partner_inst.n_pwr - n0, 2);
      rdchk(ra(5, 0), 32'h00006011);
      bus(1'b1, ra(5, 1), 16'h0000);
      rdchk(ra(5, 1), 32'h00008000);
      $display("test force done");
   endtask
   task automatic t_prio();
      bus(1'b1, ra(0, 2), 16'h0080);
      bus(1'b1, ra(1, 2), 16'h0090);
      bus(1'b1, ra(0, 1), 16'h0007);
      bus(1'b1, ra(1, 1), 16'h0007);
      bus(1'b1, ra(1, 0), 16'hC001);
      bus(1'b1, ra(0, 0), 16'h8801);
      n0 = epdma_partner_inst.n_pwr;
      p0 = epdma_partner_inst.n_prd;
      pulse(7, 1);
      chk(epdma_partner_inst.ram_mem[8'h40], {8'hA5, p0});
      chk(epdma_partner_inst.ram_mem[8'h48], {8'h00, p0 + 8'h01});
      chk(epdma_partner_inst.n_pwr - n0, 1);
      rdchk(9'h100, 32'h00000100);
      $display("test priority done");
   endtask
   task automatic t_pingpong();
      bus(1'b1, ra(6, 2), 16'h00A0);
      bus(1'b1, ra(6, 3), 16'h00B0);
      bus(1'b1, ra(6, 1), 16'h003C);
      bus(1'b1, ra(6, 0), 16'h8002);
      p0 = epdma_partner_inst.n_prd;
      pulse(60, 6);
      rdchk(9'h100, 32'h00000640);
      pulse(60, 6);
      rdchk(9'h100, 32'h00000600);
      chk(epdma_partner_inst.ram_mem[8'h58], {8'hA5, p0 + 8'h01});
      bus(1'b1, ra(6, 0), 16'h0000);
      $display("test ping-pong done");
   endtask
   task automatic t_half();
      per_ind_offset <= 11'h00A;
      bus(1'b1, ra(4, 2), 16'h0100);
      bus(1'b1, ra(4, 5), 16'h0003);
      bus(1'b1, ra(4, 1), 16'h0015);
      bus(1'b1, ra(4, 0), 16'h9020);
      p0 = epdma_partner_inst.n_prd;
      pulse(21, 4);
      chk(hit, 1'b0);
      pulse(21, 4);
      chk(hit, 1'b1);
      chk(epdma_partner_inst.ram_mem[8'h85], {8'hA5, p0 + 8'h01});
      bus(1'b1, ra(4, 0), 16'h0000);
      $display("test half done");
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      test_done();
   end
   initial begin
      {sys_rst, avs_address, avs_read, avs_write, avs_writedata} = {1'b1, 43'h0};
      avs_byteenable = 4'hF;
      per_req = '0;
      per_ind_offset = 11'h000;
      errors = 0;
      n_compared = 0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_cont();
      t_force();
      t_prio();
      t_pingpong();
      t_half();
      test_done();
   end
endmodule
